// ==== hdl/pbk_pkg.sv ====
package pbk_pkg;
  localparam logic [7:0] PBK_ADDR_CTRL_TWO = 8'hD7;
  localparam logic [7:0] PBK_ADDR_BRAKE_CTRL = 8'hDF;
  localparam logic [7:0] PBK_ADDR_RUN = 8'hE0;
  localparam logic [7:0] PBK_ADDR_IRQ_STAT = 8'hE1;
  localparam logic [7:0] PBK_ADDR_IRQ_MASK = 8'hE2;
  localparam int PBK_BIT_SRC_SEL = 7;
  localparam int PBK_BIT_PIN_POL = 6;
  localparam int PBK_BIT_PIN_EN = 5;
  localparam int PBK_BIT_BRAKE_EN = 4;
  localparam int PBK_BIT_DIV_LO = 2;
  localparam int PBK_BIT_FLAG = 0;
  localparam logic [7:0] PBK_RST_BRAKE_CTRL = 8'h00;
  localparam logic [1:0] PBK_RST_DIV = 2'h0;
  localparam logic [1:0] PBK_DIV_1 = 2'h0;
  localparam logic [1:0] PBK_DIV_2 = 2'h1;
  localparam logic [1:0] PBK_DIV_4 = 2'h2;
  localparam logic [1:0] PBK_DIV_16 = 2'h3;
  localparam logic [3:0] PBK_CNT_MAX_2 = 4'h1;
  localparam logic [3:0] PBK_CNT_MAX_4 = 4'h3;
  localparam logic [3:0] PBK_CNT_MAX_16 = 4'hF;
  localparam int PBK_NUM_CH = 4;
endpackage

// ==== hdl/pbk_pin_sync.sv ====
`timescale 1ns/1ps
module pbk_pin_sync (
  input wire logic sys_clk_i,
  input wire logic rstn_i,
  input wire logic ce_i,
  input wire logic pin_i,
  output logic level_o
);
  import pbk_pkg::*;
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic lvl;
  } pbk_sync_type;
  pbk_sync_type st_ff, nxt_st;
  always_comb begin
    nxt_st = st_ff;
    nxt_st.s1 = pin_i;
    nxt_st.s2 = st_ff.s1;
    nxt_st.s3 = st_ff.s2;
    // A change counts only once the last two stages agree
    if (st_ff.s2 == st_ff.s3) begin
      nxt_st.lvl = st_ff.s3;
    end
  end
  always_ff @(posedge sys_clk_i) begin
    if (!rstn_i) begin
      st_ff <= '0;
    end else if (ce_i) begin
      st_ff <= nxt_st;
    end
  end
  assign level_o = st_ff.lvl;
endmodule

// ==== hdl/pbk_prescaler.sv ====
`timescale 1ns/1ps
module pbk_prescaler (
  input wire logic sys_clk_i,
  input wire logic rstn_i,
  input wire logic ce_i,
  input wire logic run_i,
  input wire logic [1:0] div_i,
  output logic tick_o
);
  import pbk_pkg::*;
  typedef struct packed {
    logic [3:0] cnt;
    logic tick;
  } pbk_pre_type;
  pbk_pre_type st_ff, nxt_st;
  function automatic logic [3:0] pbk_div_max(input logic [1:0] d);
    case (d)
      PBK_DIV_2: pbk_div_max = PBK_CNT_MAX_2;
      PBK_DIV_4: pbk_div_max = PBK_CNT_MAX_4;
      PBK_DIV_16: pbk_div_max = PBK_CNT_MAX_16;
      default: pbk_div_max = 4'h0;
    endcase
  endfunction
  always_comb begin
    nxt_st = st_ff;
    nxt_st.tick = 1'b0;
    // Held at zero while stopped so the first tick after start is a fixed distance away
    if (!run_i) begin
      nxt_st.cnt = 4'h0;
    end else if (st_ff.cnt >= pbk_div_max(div_i)) begin
      nxt_st.cnt = 4'h0;
      nxt_st.tick = 1'b1;
    end else begin
      nxt_st.cnt = st_ff.cnt + 4'h1;
    end
  end
  always_ff @(posedge sys_clk_i) begin
    if (!rstn_i) begin
      st_ff <= '0;
    end else if (ce_i) begin
      st_ff <= nxt_st;
    end
  end
  assign tick_o = st_ff.tick;
endmodule

// ==== hdl/pbk_brake.sv ====
`timescale 1ns/1ps
module pbk_brake (
  input wire logic sys_clk_i,
  input wire logic rstn_i,
  input wire logic ce_i,
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  input wire logic brake_input_pin_i,
  input wire logic [pbk_pkg::PBK_NUM_CH-1:0] pwm_raw_i,
  output logic [pbk_pkg::PBK_NUM_CH-1:0] pwm_out_o,
  output logic counter_run_o,
  output logic pwm_tick_o,
  output logic brake_active_o,
  output logic irq_o
);
  import pbk_pkg::*;
  typedef struct packed {
    logic [7:0] brake_ctrl;
    logic [1:0] div;
    logic flag;
    logic run;
    logic stat;
    logic mask;
    logic [PBK_NUM_CH-1:0] pwm_out;
    logic [PBK_NUM_CH-1:0] pre;
    logic brake;
    logic [7:0] rdata;
  } pbk_brake_type;
  pbk_brake_type st_ff, nxt_st;
  logic pin_lvl;
  logic pin_active;
  logic pin_brake;
  logic brake_now;

  pbk_pin_sync u_sync (
    .sys_clk_i(sys_clk_i),
    .rstn_i(rstn_i),
    .ce_i(ce_i),
    .pin_i(brake_input_pin_i),
    .level_o(pin_lvl)
  );

  pbk_prescaler u_pre (
    .sys_clk_i(sys_clk_i),
    .rstn_i(rstn_i),
    .ce_i(ce_i),
    .run_i(st_ff.run),
    .div_i(st_ff.div),
    .tick_o(pwm_tick_o)
  );

  always_comb begin
    pin_active = (pin_lvl == st_ff.brake_ctrl[PBK_BIT_PIN_POL]);
    pin_brake = 1'b0;
    brake_now = 1'b0;
    if (st_ff.brake_ctrl[PBK_BIT_BRAKE_EN]) begin
      case ({st_ff.brake_ctrl[PBK_BIT_PIN_EN], st_ff.brake_ctrl[PBK_BIT_SRC_SEL]})
        2'h0: brake_now = 1'b1;
        2'h1: brake_now = !st_ff.run;
        2'h2: begin
          pin_brake = pin_active;
          brake_now = pin_active;
        end
        // Prohibited setting: no brake at all
        default: brake_now = 1'b0;
      endcase
    end
  end

  always_comb begin
    nxt_st = st_ff;
    nxt_st.rdata = 8'h00;
    nxt_st.brake = brake_now;
    // Unbraked level kept apart from the pins, so a brake never overwrites it
    if (st_ff.run) begin
      nxt_st.pre = pwm_raw_i;
    end
    if (brake_now) begin
      nxt_st.pwm_out = st_ff.brake_ctrl[PBK_NUM_CH-1:0];
    end else begin
      nxt_st.pwm_out = nxt_st.pre;
    end
    if (wr_i) begin
      case (addr_i)
        PBK_ADDR_BRAKE_CTRL: nxt_st.brake_ctrl = wdata_i;
        PBK_ADDR_CTRL_TWO: begin
          nxt_st.div = wdata_i[PBK_BIT_DIV_LO+1:PBK_BIT_DIV_LO];
          if (!wdata_i[PBK_BIT_FLAG]) begin
            nxt_st.flag = 1'b0;
          end
        end
        PBK_ADDR_RUN: nxt_st.run = wdata_i[0];
        PBK_ADDR_IRQ_STAT: begin
          if (wdata_i[0]) begin
            nxt_st.stat = 1'b0;
          end
        end
        PBK_ADDR_IRQ_MASK: nxt_st.mask = wdata_i[0];
        default: nxt_st = nxt_st;
      endcase
    end
    // Hardware set wins over a same-cycle software clear
    if (pin_brake) begin
      nxt_st.run = 1'b0;
      nxt_st.flag = 1'b1;
      nxt_st.stat = 1'b1;
    end
    if (rd_i) begin
      case (addr_i)
        PBK_ADDR_BRAKE_CTRL: nxt_st.rdata = st_ff.brake_ctrl;
        PBK_ADDR_CTRL_TWO: nxt_st.rdata = {4'h0, st_ff.div, 1'b0, st_ff.flag};
        PBK_ADDR_RUN: nxt_st.rdata = {7'h00, st_ff.run};
        PBK_ADDR_IRQ_STAT: nxt_st.rdata = {7'h00, st_ff.stat};
        PBK_ADDR_IRQ_MASK: nxt_st.rdata = {7'h00, st_ff.mask};
        default: nxt_st.rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rstn_i) begin
      st_ff <= '0;
      st_ff.brake_ctrl <= PBK_RST_BRAKE_CTRL;
      st_ff.div <= PBK_RST_DIV;
    end else if (ce_i) begin
      st_ff <= nxt_st;
    end
  end

  assign rdata_o = st_ff.rdata;
  assign pwm_out_o = st_ff.pwm_out;
  assign counter_run_o = st_ff.run;
  assign brake_active_o = st_ff.brake;
  assign irq_o = st_ff.stat & st_ff.mask;
endmodule

// ==== bench/pbk_brake_properties.sv ====
`timescale 1ns/1ps
module pbk_brake_properties (
  input wire logic sys_clk_i,
  input wire logic rstn_i,
  input wire logic ce_i,
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic brake_input_pin_i,
  input wire logic [3:0] pwm_out_o,
  input wire logic counter_run_o,
  input wire logic pwm_tick_o,
  input wire logic brake_active_o
);
  import pbk_pkg::*;
  logic [7:0] ctl_ff;
  logic pin_mode;
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!rstn_i);
  // Shadow of the brake control register, rebuilt from bus writes
  always_ff @(posedge sys_clk_i) begin
    if (!rstn_i) ctl_ff <= 8'h00;
    else if (ce_i && wr_i && addr_i == PBK_ADDR_BRAKE_CTRL) ctl_ff <= wdata_i;
  end
  assign pin_mode = !ctl_ff[7] && ctl_ff[5:4] == 2'h3;
  never_forced_a: assert property (!ctl_ff[4] |=> !brake_active_o)
    else $error("brake while disabled");
  bad_combo_a: assert property (ctl_ff[7] && ctl_ff[5] |=> !brake_active_o)
    else $error("brake in prohibited mode");
  sw_hold_a: assert property (!ctl_ff[7] && ctl_ff[5:4] == 2'h1 |=> brake_active_o)
    else $error("software brake missing");
  run_follow_a: assert property (ctl_ff[7] && ctl_ff[5:4] == 2'h1
    |=> brake_active_o != $past(counter_run_o)) else $error("run follow wrong");
  level_force_a: assert property (brake_active_o |-> pwm_out_o == $past(ctl_ff[3:0]))
    else $error("brake level wrong");
  pin_stop_a: assert property ($past(pin_mode) && brake_active_o |-> !counter_run_o)
    else $error("run kept on pin brake");
  pin_sync_a: assert property ($past(pin_mode) && $rose(brake_active_o)
    |-> $past(brake_input_pin_i, 4) == $past(ctl_ff[6])
    && $past(brake_input_pin_i, 5) == $past(ctl_ff[6])) else $error("pin brake too early");
  tick_stop_a: assert property (!counter_run_o [*2] |-> !pwm_tick_o)
    else $error("tick while stopped");
endmodule
bind pbk_brake pbk_brake_properties u_props (
  .sys_clk_i(sys_clk_i),
  .rstn_i(rstn_i),
  .ce_i(ce_i),
  .addr_i(addr_i),
  .wdata_i(wdata_i),
  .wr_i(wr_i),
  .brake_input_pin_i(brake_input_pin_i),
  .pwm_out_o(pwm_out_o),
  .counter_run_o(counter_run_o),
  .pwm_tick_o(pwm_tick_o),
  .brake_active_o(brake_active_o)
);

// ==== bench/pbk_pin_model.sv ====
`timescale 1ns/1ps
module pbk_pin_model (
  input wire logic level_i,
  output logic pin_o
);
  // Pin is asynchronous to the system clock
  assign pin_o = level_i;
endmodule

// ==== bench/tb.sv ====
`timescale 1ns/1ps
module tb;
  logic sys_clk_i, rstn_i, wr_i, rd_i, pin_cmd, pin, run, tick, brk, irq, ce;
  logic [7:0] addr_i, wdata_i, rdata_o;
  logic [3:0] raw, out;
  int n_errors = 0, checks = 0, nt, d;
  pbk_pin_model u_pin (.level_i(pin_cmd), .pin_o(pin));
  pbk_brake DUT (.sys_clk_i(sys_clk_i), .rstn_i(rstn_i), .ce_i(ce), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .brake_input_pin_i(pin),
    .pwm_raw_i(raw), .pwm_out_o(out), .counter_run_o(run), .pwm_tick_o(tick),
    .brake_active_o(brk), .irq_o(irq));
  initial begin
    sys_clk_i = 0;
    forever #4 sys_clk_i = ~sys_clk_i;
  end
  always @(posedge sys_clk_i) if (tick) nt++;
  task chk(input logic [7:0] s, e);
    checks++;
    if (s !== e) begin
      n_errors++;
      $display("[FAIL] %0t seen %h exp %h", $time, s, e);
    end
  endtask
  task wr(input logic [7:0] a, v);
    @(posedge sys_clk_i);
    addr_i <= a;
    wdata_i <= v;
    wr_i <= 1;
    @(posedge sys_clk_i);
    wr_i <= 0;
  endtask
  task rd(input logic [7:0] a, e);
    @(posedge sys_clk_i);
    addr_i <= a;
    rd_i <= 1;
    @(posedge sys_clk_i);
    rd_i <= 0;
    #1 chk(rdata_o, e);
  endtask
  // Packs brake, run, irq and outputs so one compare covers them all
  task st(input int n, input logic [7:0] e);
    repeat (n) @(posedge sys_clk_i);
    #1 chk({brk, run, irq, 1'b0, out}, e);
  endtask
  task complete_run;
    $display("errors %0d checks %0d", n_errors, checks);
    if (n_errors == 0 && checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    repeat (3000) @(posedge sys_clk_i);
    n_errors++;
    complete_run();
  end
  initial begin
    rstn_i = 0;
    ce = 1;
    wr_i = 0;
    rd_i = 0;
    addr_i = 0;
    wdata_i = 0;
    raw = 4'h5;
    pin_cmd = 1;
    repeat (3) @(posedge sys_clk_i);
    rstn_i <= 1;
    rd(8'hDF, 8'h00);
    rd(8'h10, 8'h00);
    $display("reset test done");
    wr(8'hDF, 8'h0F);
    wr(8'hE0, 8'h01);
    st(3, 8'h45);
    wr(8'hDF, 8'h1A);
    st(3, 8'hCA);
    wr(8'hDF, 8'h0A);
    st(3, 8'h45);
    wr(8'hDF, 8'h93);
    st(3, 8'h45);
    wr(8'hE0, 8'h00);
    st(3, 8'h83);
    wr(8'hDF, 8'hB3);
    st(3, 8'h05);
    $display("mode test done");
    wr(8'hE2, 8'h01);
    wr(8'hE0, 8'h01);
    wr(8'hDF, 8'h36);
    st(3, 8'h45);
    // A one-cycle pin pulse never reaches agreement in the synchroniser
    @(posedge sys_clk_i);
    pin_cmd <= 0;
    @(posedge sys_clk_i);
    pin_cmd <= 1;
    st(8, 8'h45);
    pin_cmd <= 0;
    st(8, 8'hA6);
    pin_cmd <= 1;
    st(8, 8'h25);
    rd(8'hD7, 8'h01);
    wr(8'hE2, 8'h00);
    st(1, 8'h05);
    wr(8'hE2, 8'h01);
    wr(8'hE1, 8'h01);
    st(1, 8'h05);
    wr(8'hD7, 8'h00);
    rd(8'hD7, 8'h00);
    wr(8'hDF, 8'h76);
    st(8, 8'hA6);
    $display("pin test done");
    wr(8'hDF, 8'h00);
    wr(8'hE1, 8'h01);
    for (d = 0; d < 4; d++) begin
      wr(8'hD7, 8'(d << 2));
      wr(8'hE0, 8'h01);
      rd(8'hD7, 8'(d << 2));
      nt = 0;
      st(64, 8'h45);
      chk(8'(nt), 8'(64 >> (d == 3 ? 4 : d)));
    end
    $display("divide test done");
    // Writes made while the clock enable is low must be lost
    wr(8'hE0, 8'h00);
    @(posedge sys_clk_i);
    ce <= 0;
    wr(8'hE0, 8'h01);
    wr(8'hDF, 8'h1F);
    st(4, 8'h05);
    @(posedge sys_clk_i);
    ce <= 1;
    rd(8'hE0, 8'h00);
    rd(8'hDF, 8'h00);
    st(2, 8'h05);
    $display("freeze test done");
    complete_run();
  end
endmodule
